// ### hdl/dtc_pkg.sv
// package for the dual timer/event counter block
// assumes a 32-bit axi4-lite register bus and a single system clock
package dtc_pkg;
  // register word indices, byte address is four times the index (printed offsets are not all multiples of four)
  localparam logic [7:0]  DTC_IDX_C0_HIGH  = 8'h0c;
  localparam logic [7:0]  DTC_IDX_C0_LOW   = 8'h0d;
  localparam logic [7:0]  DTC_IDX_C0_CTRL  = 8'h0e;
  localparam logic [7:0]  DTC_IDX_C1_HIGH  = 8'h0f;
  localparam logic [7:0]  DTC_IDX_C1_LOW   = 8'h10;
  localparam logic [7:0]  DTC_IDX_C1_CTRL  = 8'h11;
  localparam logic [7:0]  DTC_IDX_IRQ_CTRL = 8'h12;
  localparam int          DTC_ADDR_W       = 12;
  // control field positions
  localparam int          DTC_CTL_EDGE     = 3;
  localparam int          DTC_CTL_RUN      = 4;
  localparam int          DTC_CTL_MODE_LO  = 6;
  localparam int          DTC_CTL_MODE_HI  = 7;
  localparam logic [7:0]  DTC_CTL_MASK     = 8'hd8;
  localparam logic [7:0]  DTC_CTL_RESET    = 8'h00;
  // interrupt control positions
  localparam int          DTC_IRQ_EN0      = 2;
  localparam int          DTC_IRQ_EN1      = 3;
  localparam int          DTC_IRQ_FLAG0    = 5;
  localparam int          DTC_IRQ_FLAG1    = 6;
  localparam logic [7:0]  DTC_IRQ_MASK     = 8'h6c;
  // internal clock divider for the instruction clock
  localparam int          DTC_SYS_DIV      = 4;
  localparam logic [15:0] DTC_CNT_MAX      = 16'hffff;
  localparam logic [1:0]  DTC_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  DTC_RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    DTC_MODE_UNUSED = 2'b00,
    DTC_MODE_EVENT  = 2'b01,
    DTC_MODE_TIMER  = 2'b10,
    DTC_MODE_PULSE  = 2'b11
  } dtc_mode_t;
endpackage

// ### hdl/dtc_top.sv
// dual 16-bit timer/event counter with axi4-lite register access
// assumes pins and rtc tick are synchronous-capable inputs on sys_clk
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps

module dtc_top
  import dtc_pkg::*;
#(
  parameter bit USE_RTC0 = 1'b0,
  parameter bit USE_RTC1 = 1'b0
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // counter inputs
  input  wire logic                          counter0_input_pin,
  input  wire logic                          counter1_input_pin,
  input  wire logic                          realtime_oscillator,
  // interrupt and wake-up
  output logic                               counter0_irq,
  output logic                               counter1_irq,
  output logic                               wakeup,
  // axi4-lite write
  input  wire logic [dtc_pkg::DTC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [dtc_pkg::DTC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  import dtc_pkg::*;

  function automatic logic [7:0] reg_index(
    input logic [DTC_ADDR_W-1:0] addr
  );
    reg_index = addr[9:2];
  endfunction

  // write channel
  logic                  aw_held_reg;
  logic [DTC_ADDR_W-1:0] aw_addr_reg;
  logic                  w_held_reg;
  logic [7:0]            w_data_reg;
  logic                  w_lane0_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [7:0] wr_idx = reg_index(aw_addr_reg);
  wire wr_en   = wr_fire && w_lane0_reg;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  wire wr_known = (wr_idx >= DTC_IDX_C0_HIGH) &&
                  (wr_idx <= DTC_IDX_IRQ_CTRL);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= DTC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
      end
    end
  end

  // read channel
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire       rd_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_idx  = reg_index(s_axi_araddr);

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // shared interrupt control
  logic [7:0] irq_ctrl_reg;
  logic [1:0] ovf_pulse;
  logic [7:0] ctrl_rd [2];
  logic [7:0] high_rd [2];
  logic [7:0] low_rd  [2];

  wire irq_wr = wr_en && (wr_idx == DTC_IDX_IRQ_CTRL);

  // flags set by overflow win over a software clear in the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_ctrl_reg <= 8'h00;
    end else begin
      if (irq_wr) begin
        irq_ctrl_reg <= w_data_reg & DTC_IRQ_MASK;
      end
      if (ovf_pulse[0]) begin
        irq_ctrl_reg[DTC_IRQ_FLAG0] <= 1'b1;
      end
      if (ovf_pulse[1]) begin
        irq_ctrl_reg[DTC_IRQ_FLAG1] <= 1'b1;
      end
    end
  end

  assign counter0_irq = irq_ctrl_reg[DTC_IRQ_FLAG0] &&
                        irq_ctrl_reg[DTC_IRQ_EN0];
  assign counter1_irq = irq_ctrl_reg[DTC_IRQ_FLAG1] &&
                        irq_ctrl_reg[DTC_IRQ_EN1];

  logic wakeup_reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wakeup_reg <= 1'b0;
    end else begin
      wakeup_reg <= |ovf_pulse;
    end
  end
  assign wakeup = wakeup_reg;

  // the two counters
  logic [1:0] pins;
  assign pins = {counter1_input_pin, counter0_input_pin};

  // rtc oscillator level is synchronised, then its rising edge ticks
  logic       rtc_s1_reg;
  logic       rtc_s2_reg;
  logic       rtc_s3_reg;
  logic [1:0] div_reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rtc_s1_reg <= 1'b0;
      rtc_s2_reg <= 1'b0;
      rtc_s3_reg <= 1'b0;
      div_reg    <= 2'h0;
    end else begin
      rtc_s1_reg <= realtime_oscillator;
      rtc_s2_reg <= rtc_s1_reg;
      rtc_s3_reg <= rtc_s2_reg;
      div_reg    <= 2'(div_reg + 2'h1);
    end
  end
  wire sys4_tick = (div_reg == 2'(DTC_SYS_DIV - 1));
  wire rtc_tick  = rtc_s2_reg && !rtc_s3_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_cnt
      localparam logic [7:0] IDX_H = g ? DTC_IDX_C1_HIGH : DTC_IDX_C0_HIGH;
      localparam logic [7:0] IDX_L = g ? DTC_IDX_C1_LOW  : DTC_IDX_C0_LOW;
      localparam logic [7:0] IDX_C = g ? DTC_IDX_C1_CTRL : DTC_IDX_C0_CTRL;
      localparam bit         RTC   = g ? USE_RTC1 : USE_RTC0;

      logic [7:0]  ctrl_reg;
      logic [15:0] count_reg;
      logic [15:0] preload_reg;
      logic [7:0]  buf_reg;
      logic        s1_reg;
      logic        s2_reg;
      logic        s3_reg;
      logic        armed_reg;
      logic        measuring_reg;

      wire       edge_sel = ctrl_reg[DTC_CTL_EDGE];
      wire       run      = ctrl_reg[DTC_CTL_RUN];
      dtc_mode_t mode;
      assign mode = dtc_mode_t'(ctrl_reg[DTC_CTL_MODE_HI:DTC_CTL_MODE_LO]);

      wire rise       = s2_reg && !s3_reg;
      wire fall       = !s2_reg && s3_reg;
      wire act_edge   = edge_sel ? fall : rise;
      wire back_edge  = edge_sel ? rise : fall;
      wire int_tick   = RTC ? rtc_tick : sys4_tick;

      wire wr_low  = wr_en && (wr_idx == IDX_L);
      wire wr_high = wr_en && (wr_idx == IDX_H);
      wire wr_ctrl = wr_en && (wr_idx == IDX_C);
      wire rd_high = rd_take && (rd_idx == IDX_H);
      wire rd_any  = rd_take && ((rd_idx == IDX_H) || (rd_idx == IDX_L));

      logic tick;
      always_comb begin
        unique case (mode)
          DTC_MODE_EVENT:  tick = act_edge;
          DTC_MODE_TIMER:  tick = int_tick;
          DTC_MODE_PULSE:  tick = measuring_reg && int_tick;
          DTC_MODE_UNUSED: tick = 1'b0;
        endcase
      end
      wire step  = run && tick && !rd_any;
      wire ovf   = step && (count_reg == DTC_CNT_MAX);
      wire pw_end = (mode == DTC_MODE_PULSE) && run && measuring_reg &&
                    back_edge;
      wire [15:0] new_pre = {w_data_reg, buf_reg};

      assign ovf_pulse[g] = ovf;

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= pins[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end

      // pulse width sequencing
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          armed_reg     <= 1'b0;
          measuring_reg <= 1'b0;
        end else if (!run || mode != DTC_MODE_PULSE) begin
          armed_reg     <= 1'b0;
          measuring_reg <= 1'b0;
        end else if (!armed_reg) begin
          armed_reg     <= 1'b1;
          measuring_reg <= 1'b0;
        end else if (!measuring_reg && act_edge) begin
          measuring_reg <= 1'b1;
        end else if (pw_end) begin
          measuring_reg <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          ctrl_reg <= DTC_CTL_RESET;
        end else if (wr_ctrl) begin
          ctrl_reg <= w_data_reg & DTC_CTL_MASK;
        end else if (pw_end) begin
          ctrl_reg[DTC_CTL_RUN] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          buf_reg <= 8'h00;
        end else if (rd_high) begin
          buf_reg <= count_reg[7:0];
        end else if (wr_low) begin
          buf_reg <= w_data_reg;
        end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          preload_reg <= 16'h0000;
        end else if (wr_high) begin
          preload_reg <= new_pre;
        end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          count_reg <= 16'h0000;
        end else if (wr_high && !run) begin
          count_reg <= new_pre;
        end else if (ovf) begin
          count_reg <= preload_reg;
        end else if (step) begin
          count_reg <= 16'(count_reg + 16'h0001);
        end
      end

      assign ctrl_rd[g] = ctrl_reg;
      assign high_rd[g] = count_reg[15:8];
      assign low_rd[g]  = buf_reg;
    end
  endgenerate

  // read data mux
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_idx)
      DTC_IDX_C0_HIGH:  rd_byte = high_rd[0];
      DTC_IDX_C0_LOW:   rd_byte = low_rd[0];
      DTC_IDX_C0_CTRL:  rd_byte = ctrl_rd[0];
      DTC_IDX_C1_HIGH:  rd_byte = high_rd[1];
      DTC_IDX_C1_LOW:   rd_byte = low_rd[1];
      DTC_IDX_C1_CTRL:  rd_byte = ctrl_rd[1];
      DTC_IDX_IRQ_CTRL: rd_byte = irq_ctrl_reg;
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= DTC_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h000000, rd_byte};
      rresp_reg  <= rd_ok ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

// ### dv/dtc_checker.sv
// assertions on the register bus, counter0 interrupt and wake-up outputs of dtc_top
// assumes the bind at the foot attaches it to every dtc_top instance
`timescale 1ns/10ps
module dtc_checker
  import dtc_pkg::*;
(
  // clock and reset
  input logic        sys_clk,
  input logic        reset,
  // interrupt and wake-up
  input logic        counter0_irq,
  input logic        wakeup,
  // axi4-lite write
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // axi4-lite read
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // register writes land on the edge that raises the response
  sequence write_done;
    $rose(s_axi_bvalid);
  endsequence
  chk_write_answer: assert property (both_taken |=> ##1 s_axi_bvalid)
    else $error("no write response after address and data");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("no read data after address");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_byte_only: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_err_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == DTC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  chk_irq_cause: assert property ($rose(counter0_irq) |->
    write_done or ##[0:1] wakeup)
    else $error("interrupt rose without write or overflow");
  chk_irq_clear: assert property ($fell(counter0_irq) |->
    write_done)
    else $error("interrupt fell without a write");
endmodule

bind dtc_top dtc_checker dtc_checker_i (
  .sys_clk, .reset, .counter0_irq, .wakeup, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ### dv/dtc_pin_src.sv
// external pulse source driving both counter input pins
// assumes the caller runs its tasks just after a sys_clk edge
`timescale 1ns/10ps
module dtc_pin_src (
  // clock
  input  wire logic sys_clk,
  // pins toward the counter block
  output logic      counter0_input_pin,
  output logic      counter1_input_pin
);
  logic [1:0] pin = 2'b00;
  assign counter0_input_pin = pin[0];
  assign counter1_input_pin = pin[1];
  task automatic level(int ch, logic v);
    @(posedge sys_clk);
    pin[ch] <= v;
  endtask
  // n toggles w cycles apart; a large w makes a slow source
  task automatic toggle(int ch, int n, int w);
    repeat (n) begin
      repeat (w) @(posedge sys_clk);
      pin[ch] <= !pin[ch];
    end
  endtask
endmodule

// ### dv/dtc_top_tb.sv
// self-checking bench for dtc_top over axi4-lite
// assumes dtc_pkg, dtc_top, dtc_pin_src and the checker compiled first
`timescale 1ns/10ps
module dtc_top_tb;
  import dtc_pkg::*;
  logic sys_clk, reset, counter0_input_pin, counter1_input_pin;
  logic realtime_oscillator = 0, counter0_irq, counter1_irq, wakeup;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, lfsr;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [15:0] x;
  // preload model per counter, kept by ld
  logic [15:0] m_pre [2];
  logic [7:0]  b;
  int          n_fail, comparisons, cyc, wk, rdiv;

  dtc_top #(.USE_RTC0(1'b0), .USE_RTC1(1'b1)) dtc_top_i (
    .sys_clk, .reset, .counter0_input_pin, .counter1_input_pin,
    .realtime_oscillator, .counter0_irq, .counter1_irq, .wakeup,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  dtc_pin_src dtc_pin_src_i (.sys_clk, .counter0_input_pin,
    .counter1_input_pin);

  initial begin
    sys_clk = 0;
    forever #10 sys_clk = !sys_clk;
  end

  function automatic logic [31:0] nx(logic [31:0] q);
    nx = {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
  endfunction
  function automatic logic [11:0] ba(logic [7:0] i);
    ba = {2'b00, i, 2'b00};
  endfunction

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ready is raised on the second cycle, together with the write response but a cycle after read data
  task automatic wr(logic [7:0] ix, logic [7:0] d, logic [1:0] er = 0);
    logic a, w;
    int k;
    a = 0;
    w = 0;
    k = 0;
    s_axi_awaddr <= ba(ix);
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge sys_clk);
      k++;
      if (!a && s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
      if (k == 2)
        s_axi_bready <= 1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(logic [7:0] ix, output logic [31:0] d,
                    input logic [1:0] er = 0);
    logic a;
    int k;
    a = 0;
    k = 0;
    s_axi_araddr <= ba(ix);
    s_axi_arvalid <= 1;
    do begin
      @(posedge sys_clk);
      k++;
      if (!a && s_axi_arready) begin
        a = 1;
        s_axi_arvalid <= 0;
      end
      if (k == 2)
        s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 0;
    d = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
  endtask
  task automatic ld(logic [7:0] hb, logic [15:0] q);
    m_pre[hb == DTC_IDX_C1_HIGH] = q;
    wr(hb + 8'd1, q[7:0]);
    wr(hb, q[15:8]);
  endtask
  task automatic rc(logic [7:0] hb, output logic [15:0] q);
    logic [31:0] h, l;
    rd(hb, h);
    rd(hb + 8'd1, l);
    q = {h[7:0], l[7:0]};
  endtask

  always @(posedge sys_clk) begin
    rdiv <= (rdiv == 2) ? 0 : rdiv + 1;
    if (rdiv == 2)
      realtime_oscillator <= !realtime_oscillator;
    cyc++;
    if (wakeup === 1'b1)
      wk++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    reset = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 0;
    lfsr = 32'h44f6;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      rd(DTC_IDX_C0_HIGH + 8'(i), v);
      chk("reset value", v, 0);
    end
    rd(8'h00, v, DTC_RESP_SLVERR);
    chk("unmapped", v, 0);
    wr(8'h3f, 8'hff, DTC_RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      b = k[0] ? DTC_IDX_C1_HIGH : DTC_IDX_C0_HIGH;
      lfsr = nx(lfsr);
      wr(b + 8'd2, k[1] ? 8'hff : 8'h00);
      rd(b + 8'd2, v);
      chk("control", v, k[1] ? DTC_CTL_MASK : 8'h00);
      wr(b + 8'd2, 8'h00);
      ld(b, lfsr[15:0]);
      wr(b + 8'd1, lfsr[23:16]);
      rc(b, x);
      chk("preload", x, m_pre[k[0]]);
    end
    for (int k = 0; k < 4; k++) begin
      b = k[0] ? DTC_IDX_C1_HIGH : DTC_IDX_C0_HIGH;
      dtc_pin_src_i.level(k[0], k[1]);
      ld(b, 16'h0);
      wr(b + 8'd2, {4'b0101, k[1], 3'b000});
      rd(b, v);
      dtc_pin_src_i.toggle(k[0], 9, 3);
      repeat (6) @(posedge sys_clk);
      rd(b + 8'd1, v);
      chk("buffer", v, 0);
      rc(b, x);
      chk("events", x, 5);
      rd(b + 8'd2, v);
      chk("run kept", v[4], 1);
      wr(b + 8'd2, 8'h00);
    end
    wr(DTC_IDX_IRQ_CTRL, 8'h00);
    ld(DTC_IDX_C0_HIGH, 16'hfff0);
    wr(DTC_IDX_C0_CTRL, 8'h90);
    ld(DTC_IDX_C0_HIGH, 16'h1234);
    rd(DTC_IDX_C0_HIGH, v);
    chk("running load", v, 8'hff);
    v = 0;
    for (int i = 0; i < 100 && !v[DTC_IRQ_FLAG0]; i++)
      rd(DTC_IDX_IRQ_CTRL, v);
    chk("flag", v[DTC_IRQ_FLAG0], 1);
    chk("masked", counter0_irq, 0);
    wr(DTC_IDX_C0_CTRL, 8'h80);
    rd(DTC_IDX_C0_HIGH, v);
    chk("reload", v, m_pre[0][15:8]);
    wr(DTC_IDX_IRQ_CTRL, 8'h24);
    chk("irq on", counter0_irq, 1);
    wr(DTC_IDX_IRQ_CTRL, 8'h04);
    chk("irq off", counter0_irq, 0);
    chk("wakeup", wk, 1);
    wr(DTC_IDX_IRQ_CTRL, 8'h48);
    chk("irq1 on", counter1_irq, 1);
    wr(DTC_IDX_IRQ_CTRL, 8'h40);
    chk("irq1 masked", counter1_irq, 0);
    ld(DTC_IDX_C1_HIGH, 16'h0);
    wr(DTC_IDX_C1_CTRL, 8'h90);
    repeat (60) @(posedge sys_clk);
    wr(DTC_IDX_C1_CTRL, 8'h80);
    rc(DTC_IDX_C1_HIGH, x);
    chk("rtc ticks", x >= 9 && x <= 12, 1);
    dtc_pin_src_i.level(0, 1);
    ld(DTC_IDX_C0_HIGH, 16'h0);
    wr(DTC_IDX_C0_CTRL, 8'hd0);
    repeat (20) @(posedge sys_clk);
    rc(DTC_IDX_C0_HIGH, x);
    chk("level start", x, 0);
    dtc_pin_src_i.toggle(0, 5, 40);
    repeat (6) @(posedge sys_clk);
    rd(DTC_IDX_C0_CTRL, v);
    chk("run cleared", v, 8'hc0);
    rc(DTC_IDX_C0_HIGH, x);
    chk("width", x >= 9 && x <= 11, 1);
    summarize();
  end
endmodule
